// [inc/qmreg_pkg.sv]
// Constants and carrier types for the coder host register front end.
// Assumes an 8-bit host bus with 4 address lines and a 10 MHz master clock.
package qmreg_pkg;

  localparam logic [3:0] ADDR_SYS = 4'h0;
  localparam logic [3:0] ADDR_PAR = 4'h1;
  localparam logic [3:0] ADDR_CMD = 4'h2;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [3:0] ADDR_MASK = 4'h3;
  localparam logic [3:0] ADDR_LWL = 4'h4;
  localparam logic [3:0] ADDR_LWH = 4'h5;

  localparam logic [7:0] REG_RESET = 8'h00;

  localparam int PAR_TMPL = 5;
  localparam int PAR_AT_LO_W = 5;
  localparam int PAR_AT_HI = 6;

  localparam int CMD_IC = 0;
  localparam int CMD_JC = 1;
  localparam int CMD_RC = 2;
  localparam int CMD_JP = 3;

  localparam int ST_DONE = 0;
  localparam int ST_READY = 1;
  localparam int ST_MARKER = 2;
  localparam int ST_IRQ = 3;
  localparam int ST_OVF = 4;
  localparam int ST_PAUSE = 5;

  localparam int MASK_SRC_W = 4;
  localparam int MASK_MP = 7;
  localparam int LWH_W = 6;

  localparam logic [1:0] CBW_8 = 2'h0;
  localparam logic [1:0] CBW_16 = 2'h1;
  localparam logic [1:0] CBW_32 = 2'h2;

  // Field order matches the bit layout of the system register
  typedef struct packed {
    logic img_width16;
    logic img_parallel;
    logic code_byte_swap;
    logic code_lsb_first;
    logic img_reverse;
    logic [1:0] code_bus_width;
    logic soft_reset;
  } qmreg_sys_t;

  typedef struct packed {
    logic init_done;
    logic lines_done;
    logic final_read;
    logic code_ready;
    logic marker_seen;
    logic sc_overflow;
    logic decoding;
  } qmreg_core_ev_t;

  typedef struct packed {
    logic [13:0] line_width;
    logic [6:0] adaptive_offset;
    logic two_line_tmpl;
    logic ctx_init;
    logic run;
    logic ctx_xfer;
    logic pause_mode;
    logic marker_hold;
    logic core_reset;
  } qmreg_ctl_t;

endpackage : qmreg_pkg

// [src/qmreg_code_lanes.sv]
// Code data bus lane arrangement: time-ordered word to bus lanes.
// Assumes the width and order controls are stable while a word is moved.
`timescale 1ns/1ns
module qmreg_code_lanes (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [1:0] bus_width,
  input wire logic byte_swap,
  input wire logic lsb_first,
  input wire logic [31:0] word,
  output logic [31:0] lanes
);

  function automatic logic [31:0] qmreg_code_map(input logic [31:0] w, input logic [1:0] bw,
    input logic bx, input logic bs);
    logic [31:0] r;
    int nb;
    int src;
    r = '0;
    nb = (bw == qmreg_pkg::CBW_32) ? 4 : (bw == qmreg_pkg::CBW_16) ? 2 : 1;
    for (int k = 0; k < 4; k++)
    begin
      src = bx ? (nb - 1 - k) : k;
      for (int j = 0; j < 8; j++)
      begin
        if (k < nb)
          r[8 * k + j] = bs ? w[8 * src + j] : w[8 * src + 7 - j];
      end
    end
    return r;
  endfunction : qmreg_code_map

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      lanes <= 32'h0;
    else if (ce)
      lanes <= qmreg_code_map(word, bus_width, byte_swap, lsb_first);
  end

  a_code_msb_first: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && bus_width == qmreg_pkg::CBW_8 && !lsb_first
    |=> lanes[7] == $past(word[0]) && lanes[0] == $past(word[7]) && lanes[31:8] == 24'h0)
    else $error("code lane bit order wrong");

endmodule : qmreg_code_lanes

// [src/qmreg_host_regs.sv]
// Host register front end of the bilevel arithmetic coder.
// Assumes host strobes are synchronous to ref_clk and the coding core
// reports its events as one-cycle pulses on core_ev.
`timescale 1ns/1ns

// Notes on behaviour
// - Code word bits go MSB first when bit order is 0, else LSB first.
// - Earliest bit is b0, latest b31; byte and bit swaps permute lanes.
// - Leftmost pixel is p0 on the top lane; image bit order reverses it.
// - Adaptive offset is parameter bits 0-4 plus bits 6-7 as high bits.
// - Done sets on table init end, final code read, or final image read; final read sets it only while stop mode (jp) is 0.
// - Temporary stop leaves done at 0 but still raises the done interrupt.
// - Ready status bit mirrors the code DMA request output.
// - Mask bits 1, 2, 3 enable ready, marker and overflow interrupts.
// - Mask bits 0-3 gate status bits 0, 1, 2, 4; pending has no mask.
// - Interrupt output asserts while any enabled status bit is 1.
// - Interrupt drops when causes clear or their mask bits go 0.
// - Interrupts and mask register accesses never clear status bits, except pending, which follows the interrupt output.
// - With marker pause set, decoding holds as soon as a marker is seen.
// - Host may reprogram lines while held; clearing pause resumes decoding.
// - Mask bit 0 enables the completion interrupt for stop or end.
module qmreg_host_regs (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic hcs_b,
  input wire logic [3:0] ha,
  input wire logic hwr_b,
  input wire logic hrd_b,
  input wire logic [7:0] hd_in,
  output logic [7:0] hd_out,
  output logic hd_oe,
  output logic irq_out,
  output logic code_dma_request,
  input wire qmreg_pkg::qmreg_core_ev_t core_ev,
  output qmreg_pkg::qmreg_ctl_t ctl,
  input wire logic [31:0] code_word,
  output logic [31:0] code_lanes,
  input wire logic [31:0] pix_word,
  output logic [31:0] pix_lanes
);

  qmreg_pkg::qmreg_sys_t sys;
  logic [7:0] par, mask, lw_lo, status, next_rd;
  logic [qmreg_pkg::LWH_W-1:0] lw_hi;
  logic hwr_q, ic, jc, rc, jp, done, stop_ev, marker, ovf, hold;
  logic srst, sel, wr_stb, start;
  logic [qmreg_pkg::MASK_SRC_W-1:0] irq_src;
  function automatic logic wr_hit(input logic stb, input logic [3:0] a, input logic [3:0] reg_addr);
    return stb && (a == reg_addr);
  endfunction : wr_hit
  assign srst = sys.soft_reset;
  assign sel = !hcs_b;
  assign wr_stb = sel && !hwr_b && hwr_q;
  assign start = wr_hit(wr_stb, ha, qmreg_pkg::ADDR_CMD) && (hd_in[qmreg_pkg::CMD_IC] || hd_in[qmreg_pkg::CMD_JC]);
  // Write taken once, on the falling strobe edge, so a long strobe cannot retrigger a command
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      hwr_q <= 1'b1;
    else if (ce)
      hwr_q <= hwr_b;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      sys <= qmreg_pkg::qmreg_sys_t'(qmreg_pkg::REG_RESET);
    else if (ce && wr_hit(wr_stb, ha, qmreg_pkg::ADDR_SYS))
      sys <= qmreg_pkg::qmreg_sys_t'(hd_in);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      par <= qmreg_pkg::REG_RESET;
    else if (ce && wr_hit(wr_stb, ha, qmreg_pkg::ADDR_PAR))
      par <= hd_in;
  end

  // Width high byte keeps six bits
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lw_lo <= qmreg_pkg::REG_RESET;
      lw_hi <= '0;
    end
    else if (ce)
    begin
      if (wr_hit(wr_stb, ha, qmreg_pkg::ADDR_LWL))
        lw_lo <= hd_in;
      if (wr_hit(wr_stb, ha, qmreg_pkg::ADDR_LWH))
        lw_hi <= hd_in[qmreg_pkg::LWH_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      mask <= qmreg_pkg::REG_RESET;
    else if (ce)
    begin
      if (srst)
        mask <= qmreg_pkg::REG_RESET;
      else if (wr_hit(wr_stb, ha, qmreg_pkg::ADDR_MASK))
        mask <= {hd_in[qmreg_pkg::MASK_MP], 3'h0, hd_in[qmreg_pkg::MASK_SRC_W-1:0]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      ic <= 1'b0;
    else if (ce)
    begin
      if (srst)
        ic <= 1'b0;
      else if (wr_hit(wr_stb, ha, qmreg_pkg::ADDR_CMD) && hd_in[qmreg_pkg::CMD_IC])
        ic <= 1'b1;
      else if (core_ev.init_done)
        ic <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      jc <= 1'b0;
    else if (ce)
    begin
      if (srst)
        jc <= 1'b0;
      else if (wr_hit(wr_stb, ha, qmreg_pkg::ADDR_CMD) && hd_in[qmreg_pkg::CMD_JC])
        jc <= 1'b1;
      else if (core_ev.lines_done)
        jc <= 1'b0;
    end
  end

  // Transfer and stop-mode bits are plain levels from the command write
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rc <= 1'b0;
      jp <= 1'b0;
    end
    else if (ce)
    begin
      if (srst)
      begin
        rc <= 1'b0;
        jp <= 1'b0;
      end
      else if (wr_hit(wr_stb, ha, qmreg_pkg::ADDR_CMD))
      begin
        rc <= hd_in[qmreg_pkg::CMD_RC];
        jp <= hd_in[qmreg_pkg::CMD_JP];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      done <= 1'b0;
    else if (ce)
    begin
      if (srst)
        done <= 1'b0;
      else if (core_ev.init_done || (core_ev.final_read && !jp))
        done <= 1'b1;
      else if (start)
        done <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      stop_ev <= 1'b0;
    else if (ce)
    begin
      if (srst)
        stop_ev <= 1'b0;
      else if (core_ev.lines_done && jp)
        stop_ev <= 1'b1;
      else if (start)
        stop_ev <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      marker <= 1'b0;
    else if (ce)
    begin
      if (srst)
        marker <= 1'b0;
      else if (core_ev.marker_seen && core_ev.decoding)
        marker <= 1'b1;
      else if (start)
        marker <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      ovf <= 1'b0;
    else if (ce)
    begin
      if (srst)
        ovf <= 1'b0;
      else if (core_ev.sc_overflow && !core_ev.decoding)
        ovf <= 1'b1;
      else if (start)
        ovf <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      hold <= 1'b0;
    else if (ce)
    begin
      if (srst || !mask[qmreg_pkg::MASK_MP])
        hold <= 1'b0;
      else if (core_ev.marker_seen && core_ev.decoding)
        hold <= 1'b1;
    end
  end

  assign irq_src = {ovf, marker, code_dma_request, done || stop_ev};

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_out <= 1'b0;
    else if (ce)
      irq_out <= |(mask[qmreg_pkg::MASK_SRC_W-1:0] & irq_src);
  end

  assign code_dma_request = core_ev.code_ready && !srst;
  assign status = {2'h0, jp, ovf, irq_out, marker, code_dma_request, done};
  always_comb
  begin
    next_rd = 8'h0;
    case (ha)
      qmreg_pkg::ADDR_SYS: next_rd = sys;
      qmreg_pkg::ADDR_PAR: next_rd = par;
      qmreg_pkg::ADDR_STAT: next_rd = status;
      qmreg_pkg::ADDR_MASK: next_rd = mask;
      qmreg_pkg::ADDR_LWL: next_rd = lw_lo;
      qmreg_pkg::ADDR_LWH: next_rd = {2'h0, lw_hi};
      default: next_rd = 8'h0;
    endcase
  end
  // Read data registered; reads have no side effects on any flag
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      hd_out <= 8'h0;
    else if (ce && sel && !hrd_b)
      hd_out <= next_rd;
  end
  assign hd_oe = sel && !hrd_b;
  assign ctl.adaptive_offset = {par[7:qmreg_pkg::PAR_AT_HI], par[qmreg_pkg::PAR_AT_LO_W-1:0]};
  assign ctl.line_width = {lw_hi, lw_lo};
  assign ctl.two_line_tmpl = par[qmreg_pkg::PAR_TMPL];
  assign ctl.ctx_init = ic;
  assign ctl.run = jc;
  assign ctl.ctx_xfer = rc;
  assign ctl.pause_mode = jp;
  assign ctl.marker_hold = hold;
  assign ctl.core_reset = srst;

  qmreg_code_lanes u_code (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ce(ce),
    .bus_width(sys.code_bus_width),
    .byte_swap(sys.code_byte_swap),
    .lsb_first(sys.code_lsb_first),
    .word(code_word),
    .lanes(code_lanes)
  );

  qmreg_pix_lanes u_pix (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ce(ce),
    .parallel(sys.img_parallel),
    .width16(sys.img_width16),
    .reverse(sys.img_reverse),
    .pixels(pix_word),
    .lanes(pix_lanes)
  );
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_marker_hit;
    ce && !srst && mask[qmreg_pkg::MASK_MP] && core_ev.marker_seen && core_ev.decoding;
  endsequence
  sequence s_srst_two;
    ce && srst ##1 ce;
  endsequence

  a_marker_pause: assert property (s_marker_hit |=> hold && ctl.marker_hold)
    else $error("decode not held on marker");
  a_pause_resume: assert property (hold && ce && wr_hit(wr_stb, ha, qmreg_pkg::ADDR_MASK)
    && !hd_in[qmreg_pkg::MASK_MP] |=> ##1 !hold)
    else $error("clearing pause did not resume");
  a_irq_masked: assert property (ce && (mask[3:0] & irq_src) == 4'h0 |=> !irq_out)
    else $error("irq without enabled source");
  a_irq_raise: assert property (ce && done && mask[0] ##1 ce && done && mask[0] |=> irq_out)
    else $error("enabled done did not raise irq");
  a_temp_stop: assert property (ce && !srst && jp && core_ev.lines_done && !core_ev.init_done
    && !done && !start |=> !done && stop_ev)
    else $error("temporary stop set done");
  a_ctx_clear: assert property (ce && !srst && ic && core_ev.init_done
    && !wr_hit(wr_stb, ha, qmreg_pkg::ADDR_CMD) |=> !ic && done)
    else $error("init trigger not cleared");
  a_run_clear: assert property (ce && !srst && jc && core_ev.lines_done
    && !wr_hit(wr_stb, ha, qmreg_pkg::ADDR_CMD) |=> !jc)
    else $error("run trigger not cleared");
  a_ovf_set: assert property (ce && !srst && core_ev.sc_overflow && !core_ev.decoding |=> ovf)
    else $error("overflow flag missed");
  a_status_keep: assert property (ce && !srst && marker && !start |=> marker)
    else $error("marker flag lost");
  a_ready_read: assert property (ce && hd_oe && ha == qmreg_pkg::ADDR_STAT
    |=> hd_out[qmreg_pkg::ST_READY] == $past(code_dma_request))
    else $error("ready bit differs from request");
  a_soft_reset: assert property (s_srst_two |=> !irq_out && !jc && !ic && mask == 8'h0)
    else $error("soft reset did not clear logic");

endmodule : qmreg_host_regs

// [src/qmreg_pix_lanes.sv]
// Parallel image bus lane arrangement: leftmost pixel first in the word.
// Assumes serial image transfers do not use these lanes.
`timescale 1ns/1ns
module qmreg_pix_lanes (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic parallel,
  input wire logic width16,
  input wire logic reverse,
  input wire logic [31:0] pixels,
  output logic [31:0] lanes
);

  function automatic logic [31:0] qmreg_pix_map(input logic [31:0] p, input logic w16, input logic ds);
    logic [31:0] r;
    int n;
    r = '0;
    n = w16 ? 16 : 32;
    for (int i = 0; i < 32; i++)
    begin
      if (i < n)
        r[ds ? i : n - 1 - i] = p[i];
    end
    return r;
  endfunction : qmreg_pix_map

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      lanes <= 32'h0;
    else if (ce)
      lanes <= parallel ? qmreg_pix_map(pixels, width16, reverse) : 32'h0;
  end

  a_pix_left_top: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && parallel && !width16 && !reverse |=> lanes[31] == $past(pixels[0]) && lanes[0] == $past(pixels[31]))
    else $error("pixel lane order wrong");

endmodule : qmreg_pix_lanes

// [tb/qmreg_host_model.sv]
// Host processor model for the 8-bit register bus of the coder front end.
// Assumes the register block samples host strobes on rising ref_clk edges.
`timescale 1ns/1ns
module qmreg_host_model (
  input wire logic ref_clk,
  output logic hcs_b,
  output logic [3:0] ha,
  output logic hwr_b,
  output logic hrd_b,
  output logic [7:0] hd_in,
  input wire logic [7:0] hd_out,
  input wire logic hd_oe
);
  // Extra strobe cycles, so the host can be made slow
  int hold_cycles = 0;

  initial
  begin
    hcs_b = 1'h1;
    ha = 4'h0;
    hwr_b = 1'h1;
    hrd_b = 1'h1;
    hd_in = 8'h00;
  end

  // Released lines show the inverse, so a stale value never passes for data
  task automatic release_bus;
    hcs_b = 1'h1;
    hwr_b = 1'h1;
    hrd_b = 1'h1;
    ha = ~ha;
    hd_in = ~hd_in;
  endtask : release_bus

  // Strobe falls after an idle edge, so each call is exactly one write
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    hcs_b = 1'h0;
    ha = a;
    hd_in = v;
    hwr_b = 1'h0;
    repeat (1 + hold_cycles) @(posedge ref_clk);
    @(negedge ref_clk);
    release_bus();
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    hcs_b = 1'h0;
    ha = a;
    hrd_b = 1'h0;
    repeat (1 + hold_cycles) @(posedge ref_clk);
    @(negedge ref_clk);
    v = hd_oe ? hd_out : 8'hxx;
    release_bus();
  endtask : rd
endmodule : qmreg_host_model

// [tb/tb_top.sv]
// Self-checking bench for the coder host register front end.
// Assumes the host model drives the register bus; the bench plays the coding core.
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module tb_top;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } qmreg_row_t;

  localparam logic [3:0] A_SYS = qmreg_pkg::ADDR_SYS;
  localparam logic [3:0] A_PAR = qmreg_pkg::ADDR_PAR;
  localparam logic [3:0] A_CMD = qmreg_pkg::ADDR_CMD;
  localparam logic [3:0] A_STAT = qmreg_pkg::ADDR_STAT;
  localparam logic [3:0] A_MASK = qmreg_pkg::ADDR_MASK;
  localparam logic [6:0] EV_INIT = 7'h40;
  localparam logic [6:0] EV_LINES = 7'h20;
  localparam logic [6:0] EV_FINAL = 7'h10;
  localparam logic [6:0] EV_MARK = 7'h04;
  localparam logic [6:0] EV_OVF = 7'h02;

  logic ref_clk, rst_b, ce, hcs_b, hwr_b, hrd_b, hd_oe, irq_out, code_dma_request, bx, bs;
  logic [3:0] ha;
  logic [7:0] hd_in, hd_out;
  logic [31:0] code_word, code_lanes, pix_word, pix_lanes, m;
  qmreg_pkg::qmreg_core_ev_t core_ev;
  qmreg_pkg::qmreg_ctl_t ctl;
  qmreg_row_t rows [7];
  int errors = 0;
  int tests_run = 0;

  qmreg_host_regs dut_u (.ref_clk, .rst_b, .ce, .hcs_b, .ha, .hwr_b, .hrd_b, .hd_in, .hd_out, .hd_oe,
    .irq_out, .code_dma_request, .core_ev, .ctl, .code_word, .code_lanes, .pix_word, .pix_lanes);
  qmreg_host_model host_u (.ref_clk, .hcs_b, .ha, .hwr_b, .hrd_b, .hd_in, .hd_out, .hd_oe);

  initial
  begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    host_u.rd(a, v);
    `CHK(v, e)
  endtask : rd_chk

  // Core events are one-cycle pulses; two idle cycles let flag and irq settle
  task automatic pulse(input logic [6:0] p);
    @(negedge ref_clk);
    core_ev = qmreg_pkg::qmreg_core_ev_t'(core_ev | p);
    @(negedge ref_clk);
    core_ev = qmreg_pkg::qmreg_core_ev_t'(core_ev & ~p);
    repeat (2) @(negedge ref_clk);
  endtask : pulse

  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note

  function automatic logic [31:0] exp_code(input logic [31:0] w, input int n, input logic x, input logic s);
    logic [31:0] e;
    e = 32'h0;
    for (int j = 0; j < 8 * n; j++)
      e[(x ? n - 1 - j / 8 : j / 8) * 8 + (s ? j % 8 : 7 - j % 8)] = w[j];
    return e;
  endfunction : exp_code

  function automatic logic [31:0] exp_pix(input logic [31:0] w, input logic w16, input logic r);
    logic [31:0] e;
    e = 32'h0;
    for (int i = 0; i < (w16 ? 16 : 32); i++)
      e[r ? i : (w16 ? 15 : 31) - i] = w[i];
    return e;
  endfunction : exp_pix

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    tally_and_finish();
  end

  initial
  begin
    ce = 1'h1;
    rst_b = 1'h0;
    core_ev = '0;
    code_word = 32'h1e2d3c4b;
    pix_word = 32'h8c4127f5;
    rows[0] = '{A_SYS, 8'hf4, 8'hf4};
    rows[1] = '{A_PAR, 8'hc5, 8'hc5};
    rows[2] = '{A_MASK, 8'hff, 8'h8f};
    // Width 5088: within 8192, multiple of 32, 16 and 8, counted as processed
    rows[3] = '{qmreg_pkg::ADDR_LWL, 8'he0, 8'he0};
    rows[4] = '{qmreg_pkg::ADDR_LWH, 8'hd3, 8'h13};
    rows[5] = '{4'h6, 8'h55, 8'h00};
    rows[6] = '{4'hf, 8'haa, 8'h00};
    repeat (3) @(negedge ref_clk);
    rst_b = 1'h1;
    for (int a = 0; a < 6; a++)
      rd_chk(4'(a), qmreg_pkg::REG_RESET);
    `CHK(irq_out, 1'h0)
    `CHK(ctl, '0)
    note("reset");
    foreach (rows[i])
    begin
      host_u.wr(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].rexp);
    end
    `CHK(ctl.adaptive_offset, 7'h65)
    `CHK(ctl.line_width, 14'h13e0)
    `CHK(ctl.two_line_tmpl, 1'h0)
    note("registers");
    for (int cb = 0; cb < 3; cb++)
      for (int k = 0; k < 4; k++)
      begin
        bx = k[1];
        bs = k[0];
        host_u.wr(A_SYS, {bx, 1'h1, bx, bs, bs, 2'(cb), 1'h0});
        repeat (2) @(negedge ref_clk);
        m = 32'hffffffff >> (32 - 8 * (1 << cb));
        `CHK(code_lanes & m, exp_code(code_word, 1 << cb, bx, bs))
        `CHK(pix_lanes & (bx ? 32'h0000ffff : 32'hffffffff), exp_pix(pix_word, bx, bs))
      end
    host_u.wr(A_SYS, 8'h00);
    repeat (2) @(negedge ref_clk);
    `CHK(pix_lanes, 32'h0)
    note("lanes");
    host_u.wr(A_MASK, 8'h01);
    host_u.wr(A_CMD, 8'h01);
    `CHK(ctl.ctx_init, 1'h1)
    pulse(EV_INIT);
    `CHK(ctl.ctx_init, 1'h0)
    `CHK(irq_out, 1'h1)
    rd_chk(A_STAT, 8'h09);
    rd_chk(A_MASK, 8'h01);
    host_u.wr(A_MASK, 8'h01);
    rd_chk(A_STAT, 8'h09);
    host_u.wr(A_MASK, 8'h00);
    repeat (2) @(negedge ref_clk);
    `CHK(irq_out, 1'h0)
    rd_chk(A_STAT, 8'h01);
    note("done flag");
    host_u.wr(A_MASK, 8'h01);
    host_u.wr(A_CMD, 8'h0a);
    `CHK(ctl.run & ctl.pause_mode, 1'h1)
    pulse(EV_LINES);
    `CHK(ctl.run, 1'h0)
    rd_chk(A_STAT, 8'h28);
    `CHK(irq_out, 1'h1)
    host_u.wr(A_CMD, 8'h02);
    pulse(EV_FINAL);
    rd_chk(A_STAT, 8'h09);
    // Table transfer alone starts nothing: run stays up, done stays set
    host_u.wr(A_CMD, 8'h04);
    `CHK({ctl.ctx_xfer, ctl.run, ctl.pause_mode}, 3'h6)
    rd_chk(A_STAT, 8'h09);
    note("stop and end");
    host_u.hold_cycles = 2;
    host_u.wr(A_CMD, 8'h02);
    host_u.wr(A_MASK, 8'h84);
    pulse(EV_MARK);
    rd_chk(A_STAT, 8'h00);
    @(negedge ref_clk);
    core_ev.decoding = 1'h1;
    pulse(EV_MARK);
    `CHK(ctl.marker_hold, 1'h1)
    rd_chk(A_STAT, 8'h0c);
    // Host may reprogram lines here, then clears the pause bit to resume
    host_u.wr(A_MASK, 8'h04);
    repeat (2) @(negedge ref_clk);
    `CHK(ctl.marker_hold, 1'h0)
    `CHK(irq_out, 1'h1)
    host_u.hold_cycles = 0;
    note("marker");
    pulse(EV_OVF);
    rd_chk(A_STAT, 8'h0c);
    @(negedge ref_clk);
    core_ev.decoding = 1'h0;
    pulse(EV_OVF);
    host_u.wr(A_MASK, 8'h08);
    repeat (2) @(negedge ref_clk);
    rd_chk(A_STAT, 8'h1c);
    @(negedge ref_clk);
    core_ev.code_ready = 1'h1;
    @(negedge ref_clk);
    `CHK(code_dma_request, 1'h1)
    host_u.wr(A_MASK, 8'h02);
    repeat (2) @(negedge ref_clk);
    rd_chk(A_STAT, 8'h1e);
    note("overflow and ready");
    host_u.wr(A_SYS, 8'h01);
    `CHK(ctl.core_reset, 1'h1)
    `CHK(code_dma_request, 1'h0)
    rd_chk(A_STAT, 8'h00);
    rd_chk(A_MASK, 8'h00);
    rd_chk(A_PAR, 8'hc5);
    core_ev.code_ready = 1'h0;
    host_u.wr(A_SYS, 8'h00);
    `CHK(ctl.core_reset, 1'h0)
    note("soft reset");
    host_u.wr(A_MASK, 8'h01);
    host_u.wr(A_CMD, 8'h01);
    // Clock enable low freezes state, so this pulse must be lost
    ce = 1'h0;
    pulse(EV_INIT);
    `CHK(ctl.ctx_init, 1'h1)
    `CHK(irq_out, 1'h0)
    ce = 1'h1;
    note("clock enable");
    pulse(EV_INIT);
    `CHK(irq_out, 1'h1)
    @(negedge ref_clk);
    rst_b = 1'h0;
    @(negedge ref_clk);
    `CHK(irq_out, 1'h0)
    `CHK(ctl, '0)
    rst_b = 1'h1;
    rd_chk(A_PAR, 8'h00);
    note("hardware reset");
    tally_and_finish();
  end
endmodule : tb_top
